/* shared/dbcu_pkg.sv */
package dbcu_pkg;

  // ---------------------------------------------------------------
  // Widths and field positions
  // ---------------------------------------------------------------
  localparam int DBCU_ADDR_W   = 32;
  localparam int DBCU_INSTR_W  = 16;
  localparam int DBCU_OPC_MSB  = 15;
  localparam int DBCU_OPC_LSB  = 8;
  localparam int DBCU_REL_MSB  = 6;
  localparam int DBCU_REL_LSB  = 1;
  localparam int DBCU_SIGN_BIT = 0;
  localparam int DBCU_EXT_W    = 25;

  // ---------------------------------------------------------------
  // Opcodes
  // ---------------------------------------------------------------
  localparam logic [7:0] DBCU_OP_CARRY = 8'he4;
  localparam logic [7:0] DBCU_OP_EQUAL = 8'he2;
  localparam logic [7:0] DBCU_OP_GE    = 8'he9;
  localparam logic [7:0] DBCU_OP_GT    = 8'heb;
  localparam logic [7:0] DBCU_OP_HE    = 8'he5;
  localparam logic [7:0] DBCU_OP_HT    = 8'he7;
  localparam logic [7:0] DBCU_OP_LE    = 8'hea;

  // ---------------------------------------------------------------
  // Address step and reset values
  // ---------------------------------------------------------------
  localparam logic [31:0] DBCU_INSTR_BYTES = 32'h00000002;
  localparam logic [31:0] DBCU_RST_ADDR    = 32'h00000000;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef struct packed {
    logic m;
    logic n;
    logic v;
    logic z;
    logic c;
  } dbcu_flags_t;

  typedef enum logic [1:0] {
    DBCU_IDLE       = 2'b00,
    DBCU_SLOT_TAKEN = 2'b01,
    DBCU_SLOT_SEQ   = 2'b10
  } dbcu_state_t;

  localparam dbcu_state_t DBCU_RST_STATE = DBCU_IDLE;

  // Opcode belongs to this branch group
  function automatic logic dbcu_is_branch(input logic [7:0] op);
    dbcu_is_branch = (op == DBCU_OP_CARRY) || (op == DBCU_OP_EQUAL) || (op == DBCU_OP_GE) ||
                     (op == DBCU_OP_GT) || (op == DBCU_OP_HE) || (op == DBCU_OP_HT) ||
                     (op == DBCU_OP_LE);
  endfunction : dbcu_is_branch

endpackage : dbcu_pkg

/* src/dbcu_cond.sv */
`timescale 1ns/10ps
`default_nettype none
module dbcu_cond
  import dbcu_pkg::*;
(
  input  wire logic [7:0]  opcode_i,
  input  wire dbcu_flags_t flags_i,
  output logic             is_branch_o,
  output logic             take_o
);

  // ---------------------------------------------------------------
  // Opcode decode
  // ---------------------------------------------------------------
  wire logic hit_carry = (opcode_i == DBCU_OP_CARRY);
  wire logic hit_equal = (opcode_i == DBCU_OP_EQUAL);
  wire logic hit_ge    = (opcode_i == DBCU_OP_GE);
  wire logic hit_gt    = (opcode_i == DBCU_OP_GT);
  wire logic hit_he    = (opcode_i == DBCU_OP_HE);
  wire logic hit_ht    = (opcode_i == DBCU_OP_HT);
  wire logic hit_le    = (opcode_i == DBCU_OP_LE);

  // ---------------------------------------------------------------
  // Condition tests
  // ---------------------------------------------------------------
  wire logic ok_carry = hit_carry & flags_i.c;
  wire logic ok_equal = hit_equal & flags_i.z;
  wire logic ok_ge    = hit_ge & ~flags_i.n;
  wire logic ok_gt    = hit_gt & ~flags_i.n & ~flags_i.z;
  wire logic ok_he    = hit_he & ~flags_i.c;
  wire logic ok_ht    = hit_ht & ~flags_i.c & ~flags_i.z;
  wire logic ok_le    = hit_le & (flags_i.n | flags_i.z);

  assign is_branch_o = dbcu_is_branch(opcode_i);
  assign take_o      = ok_carry | ok_equal | ok_ge | ok_gt | ok_he | ok_ht | ok_le;

endmodule : dbcu_cond
`default_nettype wire

/* src/dbcu_target.sv */
`timescale 1ns/10ps
`default_nettype none
module dbcu_target
  import dbcu_pkg::*;
(
  input  wire logic [DBCU_INSTR_W-1:0] instr_i,
  input  wire logic [DBCU_ADDR_W-1:0]  instr_pc_i,
  output logic      [DBCU_ADDR_W-1:0]  disp_o,
  output logic      [DBCU_ADDR_W-1:0]  target_o
);

  // ---------------------------------------------------------------
  // Displacement fields
  // ---------------------------------------------------------------
  wire logic       sign_bit = instr_i[DBCU_SIGN_BIT];
  wire logic [DBCU_REL_MSB-DBCU_REL_LSB:0] low_rel = instr_i[DBCU_REL_MSB:DBCU_REL_LSB];

  // Sign, low field, zero: even values -128..126
  assign disp_o = {{DBCU_EXT_W{sign_bit}}, low_rel, 1'b0};

  // ---------------------------------------------------------------
  // Target from first byte after the branch
  // ---------------------------------------------------------------
  wire logic [DBCU_ADDR_W-1:0] next_addr = instr_pc_i + DBCU_INSTR_BYTES;
  assign target_o = next_addr + disp_o;

endmodule : dbcu_target
`default_nettype wire

/* src/dbcu_unit.sv */
// Functional notes
// - Carry branch loads the target into the PC only when carry is one.
// - Equal branch is taken only when zero is one.
// - Greater-or-equal branch is taken only when negative is clear.
// - Greater-than branch is taken only when negative and zero are both clear.
// - Higher-or-equal branch is taken only when carry is clear.
// - Higher-than branch is taken only when carry and zero are both clear.
// - Less-or-equal branch is taken when negative or zero is set.
// - Target is the signed displacement plus the address after the branch.
// - Displacement is sign bit extended, low field, then a zero bit, even from -128 to 126.
// - These branches never modify the condition flags or the cache mode flag.
// - The one instruction after the branch always executes, taken or not.
// - Not taken, the delay instruction runs normally and execution continues in sequence.
// - Taken, the delay instruction completes without advancing the PC that holds the target.
// - A PC read by the delay instruction of a taken branch returns the target.
`timescale 1ns/10ps
`default_nettype none
module dbcu_unit
  import dbcu_pkg::*;
(
  input  wire logic                    mclk_i,
  input  wire logic                    sys_rst_i,
  input  wire logic                    instr_valid_i,
  input  wire logic [DBCU_INSTR_W-1:0] instr_i,
  input  wire logic [DBCU_ADDR_W-1:0]  instr_pc_i,
  input  wire dbcu_flags_t             flags_i,
  input  wire logic                    delay_done_i,
  output logic                         branch_accept_o,
  output logic                         flags_keep_o,
  output logic                         branch_taken_o,
  output logic                         pc_load_o,
  output logic [DBCU_ADDR_W-1:0]       pc_target_o,
  output logic                         delay_slot_o,
  output logic                         pc_hold_o,
  output logic                         pc_read_sel_o,
  output logic [DBCU_ADDR_W-1:0]       pc_read_value_o
);

  // ---------------------------------------------------------------
  // Decode and target
  // ---------------------------------------------------------------
  logic                   is_branch;
  logic                   take;
  logic [DBCU_ADDR_W-1:0] disp;
  logic [DBCU_ADDR_W-1:0] target;

  dbcu_cond u_cond (
    .opcode_i    (instr_i[DBCU_OPC_MSB:DBCU_OPC_LSB]),
    .flags_i     (flags_i),
    .is_branch_o (is_branch),
    .take_o      (take)
  );

  dbcu_target u_target (
    .instr_i    (instr_i),
    .instr_pc_i (instr_pc_i),
    .disp_o     (disp),
    .target_o   (target)
  );

  // ---------------------------------------------------------------
  // State
  // ---------------------------------------------------------------
  dbcu_state_t            state;
  dbcu_state_t            next_state;
  logic [DBCU_ADDR_W-1:0] target_q;
  logic                   taken_q;
  logic                   load_q;

  wire logic idle       = (state == DBCU_IDLE);
  wire logic in_taken   = (state == DBCU_SLOT_TAKEN);
  wire logic in_seq     = (state == DBCU_SLOT_SEQ);
  wire logic accept     = instr_valid_i & is_branch & idle;
  wire logic accept_tk  = accept & take;
  wire logic slot_end   = ~idle & delay_done_i;

  // Next state: slot stays open until the delay instruction completes
  always_comb begin
    next_state = state;
    case (state)
      DBCU_IDLE: begin
        if (accept_tk) begin
          next_state = DBCU_SLOT_TAKEN;
        end else if (accept) begin
          next_state = DBCU_SLOT_SEQ;
        end
      end
      DBCU_SLOT_TAKEN: begin
        if (delay_done_i) begin
          next_state = DBCU_IDLE;
        end
      end
      DBCU_SLOT_SEQ: begin
        if (delay_done_i) begin
          next_state = DBCU_IDLE;
        end
      end
      default: begin
        next_state = DBCU_IDLE;
      end
    endcase
  end

  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      state <= DBCU_RST_STATE;
    end else begin
      state <= next_state;
    end
  end

  // Target captured with the branch
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      target_q <= DBCU_RST_ADDR;
    end else if (accept) begin
      target_q <= target;
    end
  end

  // One-cycle pulses after a taken branch
  always_ff @(posedge mclk_i) begin
    if (sys_rst_i) begin
      taken_q <= 1'b0;
      load_q  <= 1'b0;
    end else begin
      taken_q <= accept_tk;
      load_q  <= accept_tk;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign branch_accept_o = accept;
  assign flags_keep_o    = accept;
  assign branch_taken_o  = taken_q;
  assign pc_load_o       = load_q;
  assign pc_target_o     = target_q;
  assign delay_slot_o    = ~idle;
  assign pc_hold_o       = in_taken;
  assign pc_read_sel_o   = in_taken;
  assign pc_read_value_o = target_q;

  // ---------------------------------------------------------------
  // Reference values for the checks
  // ---------------------------------------------------------------
  wire logic        [7:0]             opc     = instr_i[DBCU_OPC_MSB:DBCU_OPC_LSB];
  wire logic signed [7:0]             ref_rel = {instr_i[DBCU_SIGN_BIT], instr_i[DBCU_REL_MSB:DBCU_REL_LSB], 1'b0};
  wire logic        [DBCU_ADDR_W-1:0] ref_tgt = instr_pc_i + DBCU_INSTR_BYTES + 32'(ref_rel);

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------

  property p_carry;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept && (opc == DBCU_OP_CARRY) |=> (branch_taken_o == $past(flags_i.c));
  endproperty
  a_carry: assert property (p_carry) else $error("carry branch decision wrong");

  property p_equal;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept && (opc == DBCU_OP_EQUAL) |=> (branch_taken_o == $past(flags_i.z));
  endproperty
  a_equal: assert property (p_equal) else $error("equal branch decision wrong");

  property p_ge;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept && (opc == DBCU_OP_GE) |=> (branch_taken_o == !$past(flags_i.n));
  endproperty
  a_ge: assert property (p_ge) else $error("greater-or-equal decision wrong");

  property p_gt;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept && (opc == DBCU_OP_GT) |=> (branch_taken_o == !($past(flags_i.n) || $past(flags_i.z)));
  endproperty
  a_gt: assert property (p_gt) else $error("greater-than decision wrong");

  property p_he;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept && (opc == DBCU_OP_HE) |=> (branch_taken_o == !$past(flags_i.c));
  endproperty
  a_he: assert property (p_he) else $error("higher-or-equal decision wrong");

  property p_ht;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept && (opc == DBCU_OP_HT) |=> (branch_taken_o == !($past(flags_i.c) || $past(flags_i.z)));
  endproperty
  a_ht: assert property (p_ht) else $error("higher-than decision wrong");

  property p_le;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept && (opc == DBCU_OP_LE) |=> (branch_taken_o == ($past(flags_i.n) || $past(flags_i.z)));
  endproperty
  a_le: assert property (p_le) else $error("less-or-equal decision wrong");

  property p_target;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept |=> (pc_target_o == $past(ref_tgt));
  endproperty
  a_target: assert property (p_target) else $error("branch target wrong");

  property p_disp;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept |-> (disp == 32'(ref_rel)) && (disp[0] == 1'b0)
                 && ($signed(disp) >= -128) && ($signed(disp) <= 126);
  endproperty
  a_disp: assert property (p_disp) else $error("displacement form wrong");

  property p_flags;
    @(posedge mclk_i) disable iff (sys_rst_i)
      instr_valid_i && dbcu_is_branch(opc) && !delay_slot_o |-> flags_keep_o;
  endproperty
  a_flags: assert property (p_flags) else $error("flags not kept on branch");

  property p_refuse;
    @(posedge mclk_i) disable iff (sys_rst_i)
      delay_slot_o |-> !branch_accept_o && !flags_keep_o;
  endproperty
  a_refuse: assert property (p_refuse) else $error("branch accepted inside a delay slot");

  property p_slot_open;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept ##1 !delay_done_i |=> delay_slot_o;
  endproperty
  a_slot_open: assert property (p_slot_open) else $error("delay slot closed early");

  property p_seq;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept && !take |=> !pc_hold_o && !pc_load_o && delay_slot_o;
  endproperty
  a_seq: assert property (p_seq) else $error("not-taken branch disturbed the PC");

  property p_seq_read;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept && !take |=> !pc_read_sel_o && !branch_taken_o;
  endproperty
  a_seq_read: assert property (p_seq_read) else $error("not-taken slot redirected PC reads");

  property p_hold;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept && take |=> pc_load_o && pc_hold_o && branch_taken_o;
  endproperty
  a_hold: assert property (p_hold) else $error("PC advanced during taken delay slot");

  property p_hold_stay;
    @(posedge mclk_i) disable iff (sys_rst_i)
      pc_hold_o && !delay_done_i |=> pc_hold_o && !pc_load_o;
  endproperty
  a_hold_stay: assert property (p_hold_stay) else $error("PC hold dropped or reloaded in slot");

  property p_slot_end;
    @(posedge mclk_i) disable iff (sys_rst_i)
      delay_slot_o && delay_done_i |=> !delay_slot_o && !pc_hold_o;
  endproperty
  a_slot_end: assert property (p_slot_end) else $error("delay slot not closed after delay instruction");

  property p_idle_stay;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !delay_slot_o && !branch_accept_o |=> !delay_slot_o;
  endproperty
  a_idle_stay: assert property (p_idle_stay) else $error("delay slot opened without a branch");

  property p_load_once;
    @(posedge mclk_i) disable iff (sys_rst_i)
      pc_load_o |=> !pc_load_o && !branch_taken_o;
  endproperty
  a_load_once: assert property (p_load_once) else $error("PC load longer than one cycle");

  property p_target_keep;
    @(posedge mclk_i) disable iff (sys_rst_i)
      !branch_accept_o |=> $stable(pc_target_o);
  endproperty
  a_target_keep: assert property (p_target_keep) else $error("branch target changed without a branch");

  property p_read;
    @(posedge mclk_i) disable iff (sys_rst_i)
      accept && take |=> pc_read_sel_o && (pc_read_value_o == $past(ref_tgt));
  endproperty
  a_read: assert property (p_read) else $error("delay slot PC read not the target");

  property p_read_stable;
    @(posedge mclk_i) disable iff (sys_rst_i)
      pc_read_sel_o && $past(pc_read_sel_o) |-> $stable(pc_read_value_o);
  endproperty
  a_read_stable: assert property (p_read_stable) else $error("delay slot PC read value moved");

  property p_fields;
    @(posedge mclk_i) disable iff (sys_rst_i)
      instr_valid_i && idle |-> (branch_accept_o == dbcu_is_branch(instr_i[15:8]));
  endproperty
  a_fields: assert property (p_fields) else $error("opcode field decode wrong");

  c_taken:    cover property (@(posedge mclk_i) disable iff (sys_rst_i) accept && take ##1 pc_load_o);
  c_not_tk:   cover property (@(posedge mclk_i) disable iff (sys_rst_i) accept && !take ##[1:4] slot_end);
  c_back:     cover property (@(posedge mclk_i) disable iff (sys_rst_i) slot_end ##[1:2] accept);
  c_neg_disp: cover property (@(posedge mclk_i) disable iff (sys_rst_i) accept && instr_i[0]);
  c_seq_end:  cover property (@(posedge mclk_i) disable iff (sys_rst_i) in_seq && delay_done_i);

endmodule : dbcu_unit
`default_nettype wire

/* tb/dbcu_unit_test.sv */
`timescale 1ns/10ps
`default_nettype none
module dbcu_unit_test
  import dbcu_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  logic              mclk_i;
  logic              sys_rst_i;
  logic              instr_valid_i;
  logic [15:0]       instr_i;
  logic [31:0]       instr_pc_i;
  dbcu_flags_t       flags_i;
  logic              delay_done_i;
  logic              branch_accept_o;
  logic              flags_keep_o;
  logic              branch_taken_o;
  logic              pc_load_o;
  logic [31:0]       pc_target_o;
  logic              delay_slot_o;
  logic              pc_hold_o;
  logic              pc_read_sel_o;
  logic [31:0]       pc_read_value_o;
  int                err_count;
  int                checks;

  dbcu_unit dbcu_unit_inst (
    .mclk_i          (mclk_i),
    .sys_rst_i       (sys_rst_i),
    .instr_valid_i   (instr_valid_i),
    .instr_i         (instr_i),
    .instr_pc_i      (instr_pc_i),
    .flags_i         (flags_i),
    .delay_done_i    (delay_done_i),
    .branch_accept_o (branch_accept_o),
    .flags_keep_o    (flags_keep_o),
    .branch_taken_o  (branch_taken_o),
    .pc_load_o       (pc_load_o),
    .pc_target_o     (pc_target_o),
    .delay_slot_o    (delay_slot_o),
    .pc_hold_o       (pc_hold_o),
    .pc_read_sel_o   (pc_read_sel_o),
    .pc_read_value_o (pc_read_value_o)
  );

  always #10 mclk_i = ~mclk_i;

  // ---------------------------------------------------------------
  // Compare and closing
  // ---------------------------------------------------------------
  task automatic chk_bit(input string name, input logic exp, input logic got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s exp %b got %b", name, exp, got);
    end
  endtask : chk_bit

  task automatic chk_word(input string name, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("[ERR] %s exp %h got %h", name, exp, got);
    end
  endtask : chk_word

  task automatic complete_run;
    $display("err_count %0d checks %0d", err_count, checks);
    if (err_count == 0 && checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // Expected condition outcome per opcode
  function automatic logic exp_take(input logic [7:0] op, input dbcu_flags_t f);
    case (op)
      8'he4:   exp_take = f.c;
      8'he2:   exp_take = f.z;
      8'he9:   exp_take = ~f.n;
      8'heb:   exp_take = ~f.n & ~f.z;
      8'he5:   exp_take = ~f.c;
      8'he7:   exp_take = ~f.c & ~f.z;
      8'hea:   exp_take = f.n | f.z;
      default: exp_take = 1'b0;
    endcase
  endfunction : exp_take

  // ---------------------------------------------------------------
  // Scenarios; each starts and ends just after a falling edge
  // ---------------------------------------------------------------
  task automatic do_branch(input logic [7:0] op, input dbcu_flags_t f, input logic [31:0] pc,
                           input logic [6:0] lo, input logic s, input int extra);
    logic        tk;
    logic [31:0] tgt;
    tk  = exp_take(op, f);
    tgt = pc + 32'h00000002 + {{25{s}}, lo[5:0], 1'b0};
    instr_valid_i = 1'b1;
    instr_i       = {op, lo, s};
    instr_pc_i    = pc;
    flags_i       = f;
    #1;
    chk_bit("accept", 1'b1, branch_accept_o);
    chk_bit("flags_keep", 1'b1, flags_keep_o);
    @(negedge mclk_i);
    instr_valid_i = (extra > 0);
    flags_i       = ~f;
    #1;
    chk_bit("taken", tk, branch_taken_o);
    chk_bit("pc_load", tk, pc_load_o);
    chk_word("target", tgt, pc_target_o);
    chk_bit("delay_slot", 1'b1, delay_slot_o);
    chk_bit("pc_hold", tk, pc_hold_o);
    chk_bit("read_sel", tk, pc_read_sel_o);
    chk_word("read_value", tgt, pc_read_value_o);
    for (int k = 0; k < extra; k++) begin
      chk_bit("slot_refuse", 1'b0, branch_accept_o);
      @(negedge mclk_i);
      instr_valid_i = (k < extra - 1);
      #1;
      chk_bit("load_once", 1'b0, pc_load_o);
      chk_bit("slot_hold", 1'b1, delay_slot_o);
      chk_bit("hold_stay", tk, pc_hold_o);
      chk_word("target_stay", tgt, pc_target_o);
    end
    delay_done_i = 1'b1;
    @(negedge mclk_i);
    delay_done_i = 1'b0;
    #1;
    chk_bit("slot_end", 1'b0, delay_slot_o);
    chk_bit("hold_end", 1'b0, pc_hold_o);
    chk_bit("taken_end", 1'b0, branch_taken_o);
  endtask : do_branch

  // All opcodes against all flag combinations, back to back
  task automatic cond_table;
    logic [7:0] ops [7] = '{8'he4, 8'he2, 8'he9, 8'heb, 8'he5, 8'he7, 8'hea};
    for (int i = 0; i < 7; i++) begin
      for (int k = 0; k < 32; k++) begin
        do_branch(ops[i], dbcu_flags_t'(k[4:0]), 32'h00001000 + k * 4, 7'(k * 5), k[0], 0);
      end
    end
  endtask : cond_table

  // Displacement extremes, address wrap and long slots with refused branches
  task automatic disp_edges;
    do_branch(8'he4, 5'h01, 32'h00002000, 7'h00, 1'b1, 0);
    do_branch(8'he4, 5'h01, 32'h00002000, 7'h7f, 1'b0, 3);
    do_branch(8'he4, 5'h01, 32'hfffffffe, 7'h7f, 1'b0, 0);
    do_branch(8'he4, 5'h00, 32'h00000000, 7'h00, 1'b1, 2);
    do_branch(8'hea, 5'h02, 32'h00003000, 7'h55, 1'b1, 4);
  endtask : disp_edges

  // Opcodes outside the group and a stray slot end are ignored
  task automatic ignore_check;
    logic [7:0] bad [7] = '{8'he8, 8'he3, 8'he1, 8'he0, 8'he6, 8'hec, 8'h00};
    for (int i = 0; i < 7; i++) begin
      instr_valid_i = 1'b1;
      instr_i       = {bad[i], 8'h2a};
      flags_i       = 5'h1f;
      delay_done_i  = 1'b1;
      #1;
      chk_bit("foreign_accept", 1'b0, branch_accept_o);
      @(negedge mclk_i);
      instr_valid_i = 1'b0;
      delay_done_i  = 1'b0;
      #1;
      chk_bit("foreign_load", 1'b0, pc_load_o);
      chk_bit("foreign_slot", 1'b0, delay_slot_o);
    end
  endtask : ignore_check

  // Reset in the middle of a taken slot
  task automatic reset_mid;
    instr_valid_i = 1'b1;
    instr_i       = 16'he203;
    flags_i       = 5'h02;
    @(negedge mclk_i);
    instr_valid_i = 1'b0;
    sys_rst_i     = 1'b1;
    @(negedge mclk_i);
    sys_rst_i = 1'b0;
    #1;
    chk_bit("rst_slot", 1'b0, delay_slot_o);
    chk_bit("rst_hold", 1'b0, pc_hold_o);
    chk_bit("rst_load", 1'b0, pc_load_o);
    chk_word("rst_target", 32'h00000000, pc_target_o);
    chk_word("rst_read", 32'h00000000, pc_read_value_o);
  endtask : reset_mid

  // ---------------------------------------------------------------
  // Main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    mclk_i        = 1'b0;
    sys_rst_i     = 1'b1;
    instr_valid_i = 1'b0;
    instr_i       = 16'h0000;
    instr_pc_i    = 32'h00000000;
    flags_i       = 5'h00;
    delay_done_i  = 1'b0;
    err_count     = 0;
    checks        = 0;
    repeat (3) @(negedge mclk_i);
    sys_rst_i = 1'b0;
    #1;
    chk_bit("idle_slot", 1'b0, delay_slot_o);
    chk_word("idle_target", 32'h00000000, pc_target_o);
    cond_table();
    disp_edges();
    ignore_check();
    reset_mid();
    do_branch(8'he7, 5'h00, 32'h00004000, 7'h10, 1'b0, 1);
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge mclk_i);
    err_count++;
    complete_run();
  end

endmodule : dbcu_unit_test
`default_nettype wire
